// File: hdl/pm_defines.svh
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH

// ***********************
// register offsets
// ***********************
`define OFF_SLEEP      8'h00
`define OFF_CPU_DIVISION_SELECT     8'h04
`define OFF_APBASEL    8'h08
`define OFF_APBBSEL    8'h0C
`define OFF_AHBMASK    8'h10
`define OFF_APBAMASK   8'h14
`define OFF_APBBMASK   8'h18
`define OFF_INTMASK    8'h1C
`define OFF_INTFLAG    8'h20
`define OFF_RCAUSE     8'h24
`define OFF_CFDCTRL    8'h28
`define OFF_SWRESET    8'h2C

// ***********************
// widths and counts
// ***********************
`define ADDR_W         8
`define DATA_W         32
`define DIV_W          3
`define PRESC_W        7
`define TICK_W         8
`define AHB_MODS       4
`define APB_MODS       8
`define SRC_W          6
`define RC_W           8
`define INT_W          2
`define CNT_W          8

// ***********************
// field positions
// ***********************
`define INT_CLOCK_SETTING_READY_FLAG      0
`define INT_CFD        1
`define RC_POR         0
`define RC_CBOD        1
`define RC_IBOD        2
`define RC_EXT         4
`define RC_WDT         5
`define RC_SYST        6
`define SRC_POR        0
`define SRC_CBOD       1
`define SRC_IBOD       2
`define SRC_EXT        3
`define SRC_WDT        4
`define SRC_SYST       5
`define CFD_EN         0
`define CFD_SAFE       1
`define SLEEP_STANDBY  0
`define SWRESET_REQ    0
`define PRESC_WRAP     7

// ***********************
// reset values
// ***********************
`define DIV_RST        3'h0
`define AHBMASK_RST    4'hF
`define APBMASK_RST    8'hFF
`define RC_RST         8'h01

// ***********************
// timing
// ***********************
`define CLK_PERIOD_NS  10
`define CFD_TIME_NS    1000
`define CFD_CYC        ((`CFD_TIME_NS) / (`CLK_PERIOD_NS))
`define RST_HOLD_NS    100
`define RST_HOLD_CYC   ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))

`endif

// File: hdl/pm_pkg.sv
`include "pm_defines.svh"

package pm_pkg;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic               wr;
    logic               rd;
  } reg_req_t;

  typedef struct packed {
    logic por;
    logic core_bod;
    logic io_bod;
    logic ext_reset_n;
    logic wdt_timeout;
  } reset_pins_t;

  typedef struct packed {
    logic                 cpu;
    logic                 ahb;
    logic                 apba;
    logic                 apbb;
    logic [`AHB_MODS-1:0] ahb_mod;
    logic [`APB_MODS-1:0] apba_mod;
    logic [`APB_MODS-1:0] apbb_mod;
  } clk_en_t;

  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'h0,
    ST_IDLE    = 2'h1,
    ST_STANDBY = 2'h3
  } sleep_state_t;

endpackage : pm_pkg

// File: hdl/clock_prescaler.sv
`timescale 1ns/1ps
`include "pm_defines.svh"

module clock_prescaler (
  input  wire logic                clk,
  input  wire logic                reset_n,
  output logic [`TICK_W-1:0]       tick
);

  logic [`PRESC_W-1:0] cnt_r;
  logic [`PRESC_W-1:0] cnt_nxt;

  assign cnt_nxt = cnt_r + `PRESC_W'h1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // tick[k]: one cycle in every 2**k, all aligned at counter wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= '1;
    end else begin
      for (int k = 0; k < `TICK_W; k++) begin
        tick[k] <= ((cnt_nxt & `PRESC_W'((1 << k) - 1)) == `PRESC_W'((1 << k) - 1));
      end
    end
  end

endmodule : clock_prescaler

// File: hdl/power_reset_clock_manager.sv
`timescale 1ns/1ps
`include "pm_defines.svh"

// What this block does
// - derives cpu, ahb, apb clocks from main
// - cpu/ahb domain plus one per apb bus
// - clock settings change on the fly
// - per module clock gate by software mask
// - failure detector switches to safe oscillator
// - standby puts regulator in low power
// - sleep halts cpu, stops mode's domains
// - interrupt or reset source wakes to active
// - gathers resets, source readable, state per source
// - power-on and both brownouts are power resets
// - pin, watchdog, software are user resets
// - prescaler divides by one to 128
// - only idle and standby sleep modes
// - domain clock is main over two^exponent
// - ready flag low until new division applies

module power_reset_clock_manager (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire pm_pkg::reg_req_t     reg_req,
  output logic [`DATA_W-1:0]        reg_rdata,
  input  wire logic                 sleep_req,
  input  wire logic                 wake_irq,
  input  wire pm_pkg::reset_pins_t  reset_pins,
  input  wire logic                 main_clk_heartbeat,
  output pm_pkg::clk_en_t           clk_en,
  output logic                      regulator_low_power,
  output logic                      safe_osc_select,
  output logic                      power_reset,
  output logic                      user_reset,
  output logic                      irq
);

  // ***********************
  // helpers
  // ***********************
  function automatic logic div_tick(input logic [`TICK_W-1:0] t,
                                    input logic [`DIV_W-1:0]  e);
    div_tick = t[e];
  endfunction : div_tick

  function automatic logic [`RC_W-1:0] cause_of(input logic [`SRC_W-1:0] s);
    cause_of = '0;
    if (s[`SRC_POR])       cause_of[`RC_POR]  = 1'b1;
    else if (s[`SRC_CBOD]) cause_of[`RC_CBOD] = 1'b1;
    else if (s[`SRC_IBOD]) cause_of[`RC_IBOD] = 1'b1;
    else if (s[`SRC_EXT])  cause_of[`RC_EXT]  = 1'b1;
    else if (s[`SRC_WDT])  cause_of[`RC_WDT]  = 1'b1;
    else if (s[`SRC_SYST]) cause_of[`RC_SYST] = 1'b1;
  endfunction : cause_of

  // ***********************
  // declarations
  // ***********************
  logic [`TICK_W-1:0]   tick;
  logic [4:0]           pin_s1_r;
  logic [4:0]           pin_s2_r;
  logic [2:0]           hb_r;
  logic [`SRC_W-1:0]    src;
  logic                 sw_req_r;
  logic                 src_power;
  logic                 src_any;
  logic [`CNT_W-1:0]    hold_r;
  logic                 kind_power_r;
  logic                 kind_power;
  logic                 in_reset_r;
  logic                 reset_start;
  logic                 user_start;
  logic                 power_start;
  logic [`RC_W-1:0]     rcause_r;
  logic [`DIV_W-1:0]    cpu_div_r;
  logic [`DIV_W-1:0]    apba_div_r;
  logic [`DIV_W-1:0]    apbb_div_r;
  logic [`DIV_W-1:0]    cpu_div_new_r;
  logic [`DIV_W-1:0]    apba_div_new_r;
  logic [`DIV_W-1:0]    apbb_div_new_r;
  logic                 div_pending_r;
  logic                 div_apply;
  logic [`AHB_MODS-1:0] ahb_mask_r;
  logic [`APB_MODS-1:0] apba_mask_r;
  logic [`APB_MODS-1:0] apbb_mask_r;
  logic [`INT_W-1:0]    intmask_r;
  logic [`INT_W-1:0]    intflag_r;
  logic [`INT_W-1:0]    int_set;
  logic                 standby_sel_r;
  logic                 cfd_en_r;
  logic [`CNT_W-1:0]    cfd_cnt_r;
  logic                 clk_dead;
  logic                 hb_edge;
  logic                 wr_sel;
  pm_pkg::sleep_state_t state_r;
  logic                 cpu_run;
  logic                 bus_run;
  logic                 cpu_tick;
  logic                 apba_tick;
  logic                 apbb_tick;
  logic [`DATA_W-1:0]   rd_mux;

  function automatic logic wr_at(input pm_pkg::reg_req_t q,
                                 input logic [`ADDR_W-1:0] a);
    wr_at = q.wr && (q.addr == a);
  endfunction : wr_at

  // ***********************
  // prescaler
  // ***********************
  clock_prescaler u_presc (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  // ***********************
  // pin synchronisers
  // ***********************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= 5'h02;
      pin_s2_r <= 5'h02;
      hb_r     <= '0;
    end else begin
      pin_s1_r <= reset_pins;
      pin_s2_r <= pin_s1_r;
      hb_r     <= {hb_r[1], hb_r[0], main_clk_heartbeat};
    end
  end

  assign src[`SRC_POR]  = pin_s2_r[4];
  assign src[`SRC_CBOD] = pin_s2_r[3];
  assign src[`SRC_IBOD] = pin_s2_r[2];
  assign src[`SRC_EXT]  = ~pin_s2_r[1];
  assign src[`SRC_WDT]  = pin_s2_r[0];
  assign src[`SRC_SYST] = sw_req_r;

  assign src_power   = |src[`SRC_IBOD:`SRC_POR];
  assign src_any     = |src;
  assign reset_start = src_any && !in_reset_r;
  assign power_start = src_power && !(in_reset_r && kind_power_r);
  assign user_start  = reset_start && !src_power;
  assign kind_power  = src_power || (in_reset_r && kind_power_r);

  // ***********************
  // reset controller
  // ***********************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_req_r <= 1'b0;
    end else begin
      sw_req_r <= wr_at(reg_req, `OFF_SWRESET) && reg_req.wdata[`SWRESET_REQ];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_r       <= '0;
      kind_power_r <= 1'b1;
      in_reset_r   <= 1'b0;
    end else begin
      if (src_any) begin
        hold_r <= `CNT_W'(`RST_HOLD_CYC);
      end else if (hold_r != '0) begin
        hold_r <= hold_r - `CNT_W'h1;
      end
      if (src_power) begin
        kind_power_r <= 1'b1;
      end else if (reset_start) begin
        kind_power_r <= 1'b0;
      end
      in_reset_r <= src_any || (hold_r > `CNT_W'h1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_reset <= 1'b0;
      user_reset  <= 1'b0;
    end else begin
      power_reset <= (src_any || hold_r > `CNT_W'h1) && kind_power;
      user_reset  <= (src_any || hold_r > `CNT_W'h1) && !kind_power;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rcause_r <= `RC_RST;
    end else if (reset_start || power_start) begin
      rcause_r <= cause_of(src);
    end
  end

  // ***********************
  // clock failure detector
  // ***********************
  assign hb_edge  = hb_r[2] ^ hb_r[1];
  assign clk_dead = (cfd_cnt_r == `CNT_W'(`CFD_CYC));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfd_cnt_r <= '0;
    end else if (hb_edge) begin
      cfd_cnt_r <= '0;
    end else if (!clk_dead) begin
      cfd_cnt_r <= cfd_cnt_r + `CNT_W'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfd_en_r        <= 1'b0;
      safe_osc_select <= 1'b0;
    end else begin
      if (power_start) begin
        cfd_en_r <= 1'b0;
      end else if (wr_at(reg_req, `OFF_CFDCTRL)) begin
        cfd_en_r <= reg_req.wdata[`CFD_EN];
      end
      if (cfd_en_r && clk_dead) begin
        safe_osc_select <= 1'b1;
      end else if (power_start) begin
        safe_osc_select <= 1'b0;
      end else if (wr_at(reg_req, `OFF_CFDCTRL) && !reg_req.wdata[`CFD_SAFE]) begin
        safe_osc_select <= 1'b0;
      end
    end
  end

  // ***********************
  // division select
  // ***********************
  assign wr_sel = wr_at(reg_req, `OFF_CPU_DIVISION_SELECT) || wr_at(reg_req, `OFF_APBASEL)
               || wr_at(reg_req, `OFF_APBBSEL);
  assign div_apply = div_pending_r && tick[`PRESC_WRAP] && !wr_sel;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_div_new_r  <= `DIV_RST;
      apba_div_new_r <= `DIV_RST;
      apbb_div_new_r <= `DIV_RST;
    end else if (power_start) begin
      cpu_div_new_r  <= `DIV_RST;
      apba_div_new_r <= `DIV_RST;
      apbb_div_new_r <= `DIV_RST;
    end else begin
      if (wr_at(reg_req, `OFF_CPU_DIVISION_SELECT)) begin
        cpu_div_new_r <= reg_req.wdata[`DIV_W-1:0];
      end
      if (wr_at(reg_req, `OFF_APBASEL)) begin
        apba_div_new_r <= reg_req.wdata[`DIV_W-1:0];
      end
      if (wr_at(reg_req, `OFF_APBBSEL)) begin
        apbb_div_new_r <= reg_req.wdata[`DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_pending_r <= 1'b0;
      cpu_div_r     <= `DIV_RST;
      apba_div_r    <= `DIV_RST;
      apbb_div_r    <= `DIV_RST;
    end else if (power_start) begin
      div_pending_r <= 1'b0;
      cpu_div_r     <= `DIV_RST;
      apba_div_r    <= `DIV_RST;
      apbb_div_r    <= `DIV_RST;
    end else if (wr_sel) begin
      div_pending_r <= 1'b1;
    end else if (div_apply) begin
      div_pending_r <= 1'b0;
      cpu_div_r     <= cpu_div_new_r;
      apba_div_r    <= apba_div_new_r;
      apbb_div_r    <= apbb_div_new_r;
    end
  end

  // ***********************
  // sleep controller
  // ***********************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= pm_pkg::ST_ACTIVE;
    end else begin
      unique case (state_r)
        pm_pkg::ST_ACTIVE: begin
          if (sleep_req && !src_any) begin
            state_r <= standby_sel_r ? pm_pkg::ST_STANDBY : pm_pkg::ST_IDLE;
          end
        end
        pm_pkg::ST_IDLE, pm_pkg::ST_STANDBY: begin
          if (wake_irq || src_any) begin
            state_r <= pm_pkg::ST_ACTIVE;
          end
        end
        default: begin
          state_r <= pm_pkg::ST_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regulator_low_power <= 1'b0;
    end else begin
      regulator_low_power <= (state_r == pm_pkg::ST_STANDBY) && !(wake_irq || src_any);
    end
  end

  // ***********************
  // clock enables
  // ***********************
  assign cpu_run   = (state_r == pm_pkg::ST_ACTIVE);
  assign bus_run   = (state_r != pm_pkg::ST_STANDBY);
  assign cpu_tick  = div_tick(tick, cpu_div_r);
  assign apba_tick = div_tick(tick, apba_div_r);
  assign apbb_tick = div_tick(tick, apbb_div_r);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_en <= '0;
    end else begin
      clk_en.cpu      <= cpu_tick && cpu_run;
      clk_en.ahb      <= cpu_tick && bus_run;
      clk_en.apba     <= apba_tick && bus_run;
      clk_en.apbb     <= apbb_tick && bus_run;
      clk_en.ahb_mod  <= {`AHB_MODS{cpu_tick && bus_run}} & ahb_mask_r;
      clk_en.apba_mod <= {`APB_MODS{apba_tick && bus_run}} & apba_mask_r;
      clk_en.apbb_mod <= {`APB_MODS{apbb_tick && bus_run}} & apbb_mask_r;
    end
  end

  // ***********************
  // control registers
  // ***********************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ahb_mask_r    <= `AHBMASK_RST;
      apba_mask_r   <= `APBMASK_RST;
      apbb_mask_r   <= `APBMASK_RST;
      intmask_r     <= '0;
      standby_sel_r <= 1'b0;
    end else if (reset_start || power_start) begin
      ahb_mask_r    <= `AHBMASK_RST;
      apba_mask_r   <= `APBMASK_RST;
      apbb_mask_r   <= `APBMASK_RST;
      intmask_r     <= '0;
      standby_sel_r <= 1'b0;
    end else begin
      if (wr_at(reg_req, `OFF_AHBMASK)) begin
        ahb_mask_r <= reg_req.wdata[`AHB_MODS-1:0];
      end
      if (wr_at(reg_req, `OFF_APBAMASK)) begin
        apba_mask_r <= reg_req.wdata[`APB_MODS-1:0];
      end
      if (wr_at(reg_req, `OFF_APBBMASK)) begin
        apbb_mask_r <= reg_req.wdata[`APB_MODS-1:0];
      end
      if (wr_at(reg_req, `OFF_INTMASK)) begin
        intmask_r <= reg_req.wdata[`INT_W-1:0];
      end
      if (wr_at(reg_req, `OFF_SLEEP)) begin
        standby_sel_r <= reg_req.wdata[`SLEEP_STANDBY];
      end
    end
  end

  // ***********************
  // interrupt flags
  // ***********************
  assign int_set[`INT_CLOCK_SETTING_READY_FLAG] = div_apply;
  assign int_set[`INT_CFD]   = cfd_en_r && clk_dead && !safe_osc_select;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intflag_r <= `INT_W'h1;
    end else begin
      for (int i = 0; i < `INT_W; i++) begin
        if (int_set[i]) begin
          intflag_r[i] <= 1'b1;
        end else if ((i == `INT_CLOCK_SETTING_READY_FLAG) && wr_sel) begin
          intflag_r[i] <= 1'b0;
        end else if (wr_at(reg_req, `OFF_INTFLAG) && reg_req.wdata[i]) begin
          intflag_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intflag_r & intmask_r);
    end
  end

  // ***********************
  // read port
  // ***********************
  always_comb begin
    rd_mux = '0;
    unique case (reg_req.addr)
      `OFF_SLEEP:    rd_mux[0] = standby_sel_r;
      `OFF_CPU_DIVISION_SELECT:   rd_mux[`DIV_W-1:0] = cpu_div_new_r;
      `OFF_APBASEL:  rd_mux[`DIV_W-1:0] = apba_div_new_r;
      `OFF_APBBSEL:  rd_mux[`DIV_W-1:0] = apbb_div_new_r;
      `OFF_AHBMASK:  rd_mux[`AHB_MODS-1:0] = ahb_mask_r;
      `OFF_APBAMASK: rd_mux[`APB_MODS-1:0] = apba_mask_r;
      `OFF_APBBMASK: rd_mux[`APB_MODS-1:0] = apbb_mask_r;
      `OFF_INTMASK:  rd_mux[`INT_W-1:0] = intmask_r;
      `OFF_INTFLAG:  rd_mux[`INT_W-1:0] = intflag_r;
      `OFF_RCAUSE:   rd_mux[`RC_W-1:0] = rcause_r;
      `OFF_CFDCTRL:  rd_mux[1:0] = {safe_osc_select, cfd_en_r};
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_req.rd ? rd_mux : '0;
    end
  end

endmodule : power_reset_clock_manager

// File: tb/far_side_model.sv
`timescale 1ns/1ps
// ***********
// far side
// ***********
module far_side_model (
  input  wire logic            clk,
  input  wire logic            hb_run,
  input  wire logic [4:0]      src,
  output pm_pkg::reset_pins_t  reset_pins,
  output logic                 main_clk_heartbeat
);
  logic hb_r = 1'b0;
  // toggles while the main clock is alive, stands still when dead
  always @(posedge clk) if (hb_run) hb_r <= ~hb_r;
  assign main_clk_heartbeat = hb_r;
  // power sources, then user sources
  assign reset_pins = '{por: src[0], core_bod: src[1], io_bod: src[2],
                        ext_reset_n: ~src[3], wdt_timeout: src[4]};
endmodule : far_side_model

// File: tb/power_reset_clock_manager_assertions.sv
`timescale 1ns/1ps
`include "pm_defines.svh"
module pm_checker (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire pm_pkg::reg_req_t     reg_req,
  input wire logic [`DATA_W-1:0]   reg_rdata,
  input wire logic                 sleep_req,
  input wire logic                 wake_irq,
  input wire pm_pkg::reset_pins_t  reset_pins,
  input wire logic                 main_clk_heartbeat,
  input wire pm_pkg::clk_en_t      clk_en,
  input wire logic                 regulator_low_power,
  input wire logic                 safe_osc_select,
  input wire logic                 power_reset,
  input wire logic                 user_reset,
  input wire logic                 irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  a_standby_gates: assert property (regulator_low_power |-> clk_en == '0)
    else $error("clock running in standby");
  a_wake_lp: assert property (regulator_low_power && wake_irq |-> ##[1:2] !regulator_low_power)
    else $error("no wake from standby");
  a_sleep_halt: assert property (sleep_req && !wake_irq && !power_reset && !user_reset
    |=> ##1 !clk_en.cpu) else $error("cpu clock not halted");
  a_ahb_mod_gate: assert property ((clk_en.ahb_mod & ~{`AHB_MODS{clk_en.ahb}}) == '0)
    else $error("ahb module clock without domain");
  a_apb_mod_gate: assert property ((clk_en.apba_mod & ~{`APB_MODS{clk_en.apba}}) == '0 &&
    (clk_en.apbb_mod & ~{`APB_MODS{clk_en.apbb}}) == '0) else $error("apb module clock");
  a_cpu_with_ahb: assert property (clk_en.cpu |-> clk_en.ahb)
    else $error("cpu clock without ahb clock");
  a_power_src: assert property ($rose(reset_pins.por) || $rose(reset_pins.core_bod) ||
    $rose(reset_pins.io_bod) |-> ##[1:4] power_reset) else $error("power reset missing");
  a_user_src: assert property ($fell(reset_pins.ext_reset_n) || $rose(reset_pins.wdt_timeout)
    |-> ##[1:4] user_reset) else $error("user reset missing");
  a_reset_hold: assert property ($fell(reset_pins.por) |=> power_reset [*8])
    else $error("power reset released early");
  a_power_cause: assert property ($rose(power_reset) |-> $past(reset_pins.por, 3) ||
    $past(reset_pins.core_bod, 3) || $past(reset_pins.io_bod, 3))
    else $error("power reset without power source");
  a_clock_setting_ready_flag_low: assert property ((reg_req.wr && (reg_req.addr == `OFF_CPU_DIVISION_SELECT ||
    reg_req.addr == `OFF_APBASEL || reg_req.addr == `OFF_APBBSEL)) ##1
    (reg_req.rd && reg_req.addr == `OFF_INTFLAG) |=> !reg_rdata[`INT_CLOCK_SETTING_READY_FLAG])
    else $error("ready flag high after select write");
endmodule : pm_checker

bind power_reset_clock_manager pm_checker i_pm_checker (
  .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .sleep_req(sleep_req), .wake_irq(wake_irq), .reset_pins(reset_pins),
  .main_clk_heartbeat(main_clk_heartbeat), .clk_en(clk_en),
  .regulator_low_power(regulator_low_power), .safe_osc_select(safe_osc_select),
  .power_reset(power_reset), .user_reset(user_reset), .irq(irq));

// File: tb/tb_power_reset_clock_manager.sv
`timescale 1ns/1ps
`include "pm_defines.svh"
module tb_power_reset_clock_manager;
  logic                clk = 1'b0;
  logic                reset_n = 1'b0;
  logic                sleep_req = 1'b0;
  logic                wake_irq = 1'b0;
  logic                hb_run = 1'b1;
  logic [4:0]          src = 5'h00;
  pm_pkg::reg_req_t    reg_req = '0;
  logic [`DATA_W-1:0]  reg_rdata;
  logic [`DATA_W-1:0]  rd_val;
  pm_pkg::reset_pins_t reset_pins;
  logic                hb;
  pm_pkg::clk_en_t     clk_en;
  logic                lp, safe, pwr, usr, irq;
  int                  failures = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  int                  n_cpu, n_apb;
  logic [7:0]          sa[6] = '{`OFF_APBASEL, `OFF_CPU_DIVISION_SELECT, `OFF_APBASEL, `OFF_CPU_DIVISION_SELECT,
                                 `OFF_CPU_DIVISION_SELECT, `OFF_APBASEL};
  logic [31:0]         sd[6] = '{32'h3, 32'h2, 32'h7, 32'h7, 32'h0, 32'h0};
  int                  ec[6] = '{0, 64, 0, 2, 0, 256};
  int                  ea[6] = '{0, 32, 0, 2, 0, 256};
  logic [31:0]         rc[6] = '{32'h01, 32'h02, 32'h04, 32'h10, 32'h20, 32'h40};

  power_reset_clock_manager i_power_reset_clock_manager (
    .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sleep_req(sleep_req), .wake_irq(wake_irq), .reset_pins(reset_pins),
    .main_clk_heartbeat(hb), .clk_en(clk_en), .regulator_low_power(lp),
    .safe_osc_select(safe), .power_reset(pwr), .user_reset(usr), .irq(irq));
  far_side_model i_far_side_model (
    .clk(clk), .hb_run(hb_run), .src(src), .reset_pins(reset_pins), .main_clk_heartbeat(hb));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      wrap_up();
    end
  end

  // ***********
  // bus and helper tasks
  // ***********
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '0;
  endtask : wr
  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1;
    check(what, reg_rdata, exp);
  endtask : rchk
  task count(input int n);
    n_cpu = 0;
    n_apb = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_cpu += int'(clk_en.cpu);
      n_apb += int'(clk_en.apba);
    end
  endtask : count
  task poke(input int w);
    @(posedge clk);
    if (w == 0) sleep_req <= 1'b1; else wake_irq <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    wake_irq <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : poke
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rchk("rcause", `OFF_RCAUSE, 32'h00000001);
    rchk("intflag", `OFF_INTFLAG, 32'h00000001);
    rchk("cpu_division_select", `OFF_CPU_DIVISION_SELECT, 32'h00000000);
    rchk("apbbsel", `OFF_APBBSEL, 32'h00000000);
    rchk("apbamask", `OFF_APBAMASK, 32'h000000FF);
    rchk("unmapped", 8'h30, 32'h00000000);
    wr(`OFF_APBAMASK, 32'h00000005);
    wr(`OFF_AHBMASK, 32'h00000003);
    repeat (2) @(posedge clk);
    #1;
    check("apba_mod", {24'h0, clk_en.apba_mod}, 32'h00000005);
    check("ahb_mod", {28'h0, clk_en.ahb_mod}, 32'h00000003);
    check("apbb_mod", {24'h0, clk_en.apbb_mod}, 32'h000000FF);
    wr(`OFF_INTMASK, 32'h00000001);
    wr(`OFF_INTFLAG, 32'h00000001);
    repeat (2) @(posedge clk);
    #1;
    check("irq", {31'h0, irq}, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      reg_req <= '{addr: sa[i], wdata: sd[i], wr: 1'b1, rd: 1'b0};
      rchk("clock_setting_ready_flag low", `OFF_INTFLAG, 32'h00000000);
      repeat (140) @(posedge clk);
      rchk("select", sa[i], sd[i]);
      rchk("clock_setting_ready_flag", `OFF_INTFLAG, 32'h00000001);
      check("irq", {31'h0, irq}, 32'h00000001);
      if (ec[i] != 0) begin
        count(256);
        check("cpu rate", n_cpu, ec[i]);
        check("apb rate", n_apb, ea[i]);
      end
    end
    check("safe idle", {31'h0, safe}, 32'h00000000);
    wr(`OFF_CFDCTRL, 32'h00000001);
    hb_run <= 1'b0;
    repeat (150) @(posedge clk);
    #1;
    check("safe osc", {31'h0, safe}, 32'h00000001);
    rchk("fail flag", `OFF_INTFLAG, 32'h00000003);
    @(posedge clk);
    hb_run <= 1'b1;
    repeat (6) @(posedge clk);
    wr(`OFF_CFDCTRL, 32'h00000000);
    rchk("cfd off", `OFF_CFDCTRL, 32'h00000000);
    wr(`OFF_SLEEP, 32'h00000000);
    poke(0);
    count(16);
    check("idle cpu", n_cpu, 0);
    check("idle apb", n_apb, 16);
    poke(1);
    count(16);
    check("woken cpu", n_cpu, 16);
    wr(`OFF_AHBMASK, 32'h00000000);
    wr(`OFF_APBAMASK, 32'h00000000);
    wr(`OFF_APBBMASK, 32'h00000000);
    wr(`OFF_SLEEP, 32'h00000001);
    poke(0);
    check("regulator", {31'h0, lp}, 32'h00000001);
    count(16);
    check("standby clocks", n_cpu + n_apb, 0);
    poke(1);
    check("regulator", {31'h0, lp}, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      if (i < 5) src <= 5'h01 << i;
      else reg_req <= '{addr: `OFF_SWRESET, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      reg_req <= '0;
      repeat (4) @(posedge clk);
      #1;
      check("power_reset", {31'h0, pwr}, (i < 3) ? 32'h1 : 32'h0);
      check("user_reset", {31'h0, usr}, (i >= 3) ? 32'h1 : 32'h0);
      @(posedge clk);
      src <= 5'h00;
      repeat (30) @(posedge clk);
      rchk("cause", `OFF_RCAUSE, rc[i]);
    end
    wrap_up();
  end
endmodule : tb_power_reset_clock_manager
